// File: src/ebw_pkg.sv
// shared constants for the external bus wait and dummy read controller
package ebw_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [19:0] DATA_EXT_LO = 20'h01200;
  localparam logic [19:0] PROG_EXT_LO = 20'h10000;
  localparam logic [19:0] ADDR_MAX    = 20'hFFFFF;

  // ----------------------------------------------------------------
  // bus cycle lengths, in clocks of strobe low time
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 5;
  localparam logic [4:0]  PROG_BASE_CYC = 5'h01;
  localparam logic [4:0]  DATA_BASE_CYC = 5'h01;
  // automatic extra cycles on each external data byte (2 or 3 allowed)
  localparam logic [4:0]  DATA_AUTO_CYC = 5'h03;
  localparam int          WAIT_W        = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [19:0] ADDR_RST  = 20'h00000;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;

endpackage

// File: src/ebw_dummy_decode.sv
// decoder: prefixed instruction pairs that issue dummy reads before a write
`timescale 1ns/1ps
module ebw_dummy_decode (
  // instruction fields
  input  wire logic [7:0] addressing_field_i,
  input  wire logic [7:0] operation_field_i,
  input  wire logic       word_i,
  // result
  output logic            dummy_hit_o
);

  logic bop;
  logic badr;
  logic wop;
  logic wadr;

  always_comb begin
    bop  = 1'b0;
    badr = 1'b0;
    wop  = 1'b0;
    wadr = 1'b0;
    // byte and bit operations, set/reset/move bit carry the bit number
    if (operation_field_i[7:3] == 5'h01 || operation_field_i[7:3] == 5'h00 ||
        operation_field_i[7:3] == 5'h03) begin
      bop = 1'b1;
    end
    case (operation_field_i)
      8'hB8, 8'hB9, 8'hCA, 8'hBB, 8'hBA, 8'hAA, 8'hAB, 8'hC7, 8'hD7: bop = 1'b1;
      default: ;
    endcase
    if (addressing_field_i[7:3] == 5'h0D) begin
      badr = 1'b1;
    end
    case (addressing_field_i)
      8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB5, 8'hB7, 8'hB8, 8'hB9, 8'h9B, 8'hBA, 8'hBB: badr = 1'b1;
      default: ;
    endcase
    case (operation_field_i)
      8'hAA, 8'hAB, 8'hC7, 8'hD7: wop = 1'b1;
      default: ;
    endcase
    if (addressing_field_i[7:2] == 6'h19) begin
      wadr = 1'b1;
    end
    case (addressing_field_i)
      8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA5, 8'hA7, 8'hA8, 8'hA9, 8'h8B, 8'hAA, 8'hAB: wadr = 1'b1;
      default: ;
    endcase
    dummy_hit_o = word_i ? (wop & wadr) : (bop & badr);
  end

endmodule

// File: src/ebw_ctrl.sv
// external memory bus master with wait insertion and dummy read strobes
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module ebw_ctrl (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // cpu request
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic        req_fetch_i,
  input  wire logic        req_write_i,
  input  wire logic        req_word_i,
  input  wire logic        req_prefixed_i,
  input  wire logic [19:0] req_addr_i,
  input  wire logic [7:0]  req_addressing_field_i,
  input  wire logic [7:0]  req_operation_field_i,
  input  wire logic [15:0] req_wdata_i,
  // wait settings
  input  wire logic [2:0]  program_wait_count_i,
  input  wire logic [2:0]  data_wait_count_i,
  // cpu answer
  output logic             rsp_valid_o,
  output logic             rsp_internal_o,
  output logic [15:0]      rsp_rdata_o,
  // external bus pins
  input  wire logic        external_access_select_n_i,
  output logic [19:0]      mem_addr_o,
  input  wire logic [7:0]  mem_data_i,
  output logic [7:0]       mem_data_o,
  output logic             mem_data_oe_o,
  output logic             program_fetch_strobe_n_o,
  output logic             mem_rd_n_o,
  output logic             mem_wr_n_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE} ebw_state_t;

  typedef struct packed {
    ebw_state_t  st;
    logic [4:0]  cnt;
    logic [1:0]  dummy_left;
    logic        byte_hi;
    logic        fetch;
    logic        write;
    logic        word;
    logic [19:0] base;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rsp;
    logic        rsp_int;
    logic [19:0] addr_pin;
    logic [7:0]  dout;
    logic        doe;
    logic        pfs_n;
    logic        rd_n;
    logic        wr_n;
    logic        ea_s1;
    logic        ea_s2;
    logic [7:0]  din_s1;
    logic [7:0]  din_s2;
  } ebw_regs_t;

  localparam ebw_regs_t REGS_RST = '{st: ST_IDLE, cnt: 5'h00, dummy_left: 2'h0, byte_hi: 1'b0,
                                     fetch: 1'b0, write: 1'b0, word: 1'b0,
                                     base: ebw_pkg::ADDR_RST, wdata: ebw_pkg::WORD_RST,
                                     rdata: ebw_pkg::WORD_RST, rsp: 1'b0, rsp_int: 1'b0,
                                     addr_pin: ebw_pkg::ADDR_RST, dout: ebw_pkg::BYTE_RST,
                                     doe: 1'b0, pfs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                     ea_s1: 1'b1, ea_s2: 1'b1,
                                     din_s1: ebw_pkg::BYTE_RST, din_s2: ebw_pkg::BYTE_RST};

  ebw_regs_t q_reg;
  ebw_regs_t q_next;
  logic      dummy_hit;
  logic      ext;

  ebw_dummy_decode u_decode (
    .addressing_field_i (req_addressing_field_i),
    .operation_field_i  (req_operation_field_i),
    .word_i             (req_word_i),
    .dummy_hit_o        (dummy_hit)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_next        = q_reg;
    q_next.rsp    = 1'b0;
    q_next.ea_s1  = external_access_select_n_i;
    q_next.ea_s2  = q_reg.ea_s1;
    q_next.din_s1 = mem_data_i;
    q_next.din_s2 = q_reg.din_s1;
    if (req_fetch_i) begin
      ext = !q_reg.ea_s2 || (req_addr_i >= ebw_pkg::PROG_EXT_LO);
    end else begin
      ext = (req_addr_i >= ebw_pkg::DATA_EXT_LO);
    end
    case (q_reg.st)
      ST_IDLE: begin
        if (req_valid_i) begin
          if (!ext) begin
            q_next.rsp     = 1'b1;
            q_next.rsp_int = 1'b1;
            q_next.rdata   = ebw_pkg::WORD_RST;
          end else begin
            q_next.st      = ST_SETUP;
            q_next.rsp_int = 1'b0;
            q_next.fetch   = req_fetch_i;
            q_next.write   = req_write_i && !req_fetch_i;
            q_next.word    = req_word_i && !req_fetch_i;
            q_next.base    = req_addr_i;
            q_next.wdata   = req_wdata_i;
            q_next.rdata   = ebw_pkg::WORD_RST;
            q_next.byte_hi = 1'b0;
            q_next.dummy_left = 2'h0;
            if (!req_fetch_i && req_write_i && req_prefixed_i && dummy_hit) begin
              q_next.dummy_left = req_word_i ? 2'h2 : 2'h1;
            end
          end
        end
      end
      ST_SETUP: begin
        q_next.st       = ST_STROBE;
        q_next.addr_pin = q_reg.base + {19'h00000, q_reg.byte_hi};
        if (q_reg.fetch) begin
          q_next.pfs_n = 1'b0;
          q_next.cnt   = ebw_pkg::PROG_BASE_CYC + {2'h0, program_wait_count_i} - 5'h01;
        end else begin
          q_next.cnt = ebw_pkg::DATA_BASE_CYC + ebw_pkg::DATA_AUTO_CYC
                       + {2'h0, data_wait_count_i} - 5'h01;
          if (q_reg.dummy_left != 2'h0 || !q_reg.write) begin
            q_next.rd_n = 1'b0;
          end else begin
            q_next.wr_n = 1'b0;
            q_next.doe  = 1'b1;
            q_next.dout = q_reg.byte_hi ? q_reg.wdata[15:8] : q_reg.wdata[7:0];
          end
        end
      end
      ST_STROBE: begin
        if (q_reg.cnt != 5'h00) begin
          q_next.cnt = q_reg.cnt - 5'h01;
        end else begin
          q_next.pfs_n = 1'b1;
          q_next.rd_n  = 1'b1;
          q_next.wr_n  = 1'b1;
          q_next.doe   = 1'b0;
          if (q_reg.dummy_left != 2'h0) begin
            q_next.byte_hi    = (q_reg.dummy_left == 2'h2);
            q_next.dummy_left = q_reg.dummy_left - 2'h1;
            q_next.st         = ST_SETUP;
          end else begin
            if (!q_reg.write) begin
              if (q_reg.byte_hi) begin
                q_next.rdata[15:8] = q_reg.din_s2;
              end else begin
                q_next.rdata[7:0] = q_reg.din_s2;
              end
            end
            if (q_reg.word && !q_reg.byte_hi) begin
              q_next.byte_hi = 1'b1;
              q_next.st      = ST_SETUP;
            end else begin
              q_next.rsp = 1'b1;
              q_next.st  = ST_IDLE;
            end
          end
        end
      end
      default: q_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_reg <= REGS_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready_o              = (q_reg.st == ST_IDLE);
  assign rsp_valid_o              = q_reg.rsp;
  assign rsp_internal_o           = q_reg.rsp_int;
  assign rsp_rdata_o              = q_reg.rdata;
  assign mem_addr_o               = q_reg.addr_pin;
  assign mem_data_o               = q_reg.dout;
  assign mem_data_oe_o            = q_reg.doe;
  assign program_fetch_strobe_n_o = q_reg.pfs_n;
  assign mem_rd_n_o               = q_reg.rd_n;
  assign mem_wr_n_o               = q_reg.wr_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [4:0] low_cnt;
  logic [4:0] exp_len;
  logic [1:0] rd_seen;
  logic [1:0] wr_seen;
  logic [1:0] exp_dummy;
  logic       plain_wr;
  logic       accept;

  assign accept = req_valid_i && req_ready_o;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt   <= 5'h00;
      exp_len   <= 5'h00;
      rd_seen   <= 2'h0;
      wr_seen   <= 2'h0;
      exp_dummy <= 2'h0;
      plain_wr  <= 1'b0;
    end else begin
      low_cnt <= (!mem_rd_n_o || !mem_wr_n_o || !program_fetch_strobe_n_o) ? low_cnt + 5'h01 : 5'h00;
      if (accept) begin
        exp_len   <= req_fetch_i ? 5'h01 + {2'h0, program_wait_count_i} : 5'h04 + {2'h0, data_wait_count_i};
        rd_seen   <= 2'h0;
        wr_seen   <= 2'h0;
        exp_dummy <= (req_prefixed_i && dummy_hit) ? (req_word_i ? 2'h2 : 2'h1) : 2'h0;
        plain_wr  <= !req_prefixed_i;
      end else begin
        if ($fell(mem_rd_n_o)) rd_seen <= rd_seen + 2'h1;
        if ($fell(mem_wr_n_o)) wr_seen <= wr_seen + 2'h1;
      end
    end
  end

  sequence fetch_accept_s;
    accept && req_fetch_i && !q_reg.ea_s2;
  endsequence

  sequence strobe_low_s;
    ##2 !program_fetch_strobe_n_o;
  endsequence

  fetch_len_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(program_fetch_strobe_n_o) |-> low_cnt == exp_len)
    else $error("fetch strobe length wrong");

  data_len_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ($rose(mem_rd_n_o) || $rose(mem_wr_n_o)) |-> low_cnt == exp_len)
    else $error("data strobe length wrong");

  dummy_count_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ($fell(mem_wr_n_o) && wr_seen == 2'h0) |-> rd_seen == exp_dummy)
    else $error("dummy read count wrong");

  plain_nodummy_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ($fell(mem_wr_n_o) && plain_wr) |-> rd_seen == 2'h0)
    else $error("plain write issued read strobe");

  internal_data_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (accept && !req_fetch_i && req_addr_i < ebw_pkg::DATA_EXT_LO)
      |=> rsp_valid_o && rsp_internal_o && mem_rd_n_o && mem_wr_n_o)
    else $error("internal data access reached bus");

  ext_fetch_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    fetch_accept_s |-> strobe_low_s)
    else $error("external fetch strobe missing");

  addr_hold_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (low_cnt != 5'h00 && $past(low_cnt) != 5'h00) |-> $stable(mem_addr_o))
    else $error("address moved during strobe");

  word_two_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (rsp_valid_o && !rsp_internal_o && q_reg.word && q_reg.write) |-> wr_seen == 2'h2)
    else $error("word write not two bytes");

  write_drive_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !mem_wr_n_o |-> mem_data_oe_o && mem_rd_n_o)
    else $error("write strobe without data drive");

endmodule

// File: sim/ebw_mem_model.sv
// behavioural external rom, ram or peripheral on the separate address and data pins
`timescale 1ns/1ps
module ebw_mem_model (
  // clock
  input  wire logic        mclk_i,
  // bus pins from the controller
  input  wire logic [19:0] bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        fetch_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  // read data to the controller
  output logic      [7:0]  bus_rdata_o
);
  logic [7:0]  mem [logic [19:0]];
  logic [21:0] ev [$];
  logic [19:0] prev_addr = 20'h00000;
  logic [7:0]  last      = 8'h00;
  logic        prev_low  = 1'b0;
  logic        prev_rd   = 1'b1;
  logic        prev_wr   = 1'b1;
  logic        prev_fe   = 1'b1;
  int          hold_err  = 0;

  function automatic logic [7:0] peek(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'hA5);
  endfunction

  // data only while a read strobe is low; a released bus shows the inverse of the last byte
  always_comb begin
    if (!rd_n_i || !fetch_n_i) begin
      bus_rdata_o = peek(bus_addr_i);
    end else begin
      bus_rdata_o = ~last;
    end
  end

  // log every strobe start, store writes, watch address hold
  always @(posedge mclk_i) begin
    if (!rd_n_i || !fetch_n_i) last <= peek(bus_addr_i);
    if (!fetch_n_i && prev_fe) ev.push_back({2'h2, bus_addr_i});
    if (!rd_n_i && prev_rd) ev.push_back({2'h0, bus_addr_i});
    if (!wr_n_i && prev_wr) ev.push_back({2'h1, bus_addr_i});
    if (!wr_n_i) mem[bus_addr_i] = bus_wdata_i;
    if (!(rd_n_i && wr_n_i && fetch_n_i) && prev_low && bus_addr_i !== prev_addr) hold_err++;
    prev_low  = !(rd_n_i && wr_n_i && fetch_n_i);
    prev_addr = bus_addr_i;
    prev_rd   = rd_n_i;
    prev_wr   = wr_n_i;
    prev_fe   = fetch_n_i;
  end
endmodule

// File: sim/testbench.sv
// self-checking bench for the external bus wait and dummy read controller
`timescale 1ns/1ps
module testbench;
  logic        mclk_i = 1'b0;
  logic        nrst_i, req_valid_i, req_fetch_i, req_write_i, req_word_i, req_prefixed_i;
  logic [19:0] req_addr_i, mem_addr_o;
  logic [7:0]  req_addressing_field_i, req_operation_field_i, mem_data_i, mem_data_o;
  logic [15:0] req_wdata_i, rsp_rdata_o;
  logic [2:0]  program_wait_count_i, data_wait_count_i;
  logic        req_ready_o, rsp_valid_o, rsp_internal_o, external_access_select_n_i;
  logic        mem_data_oe_o, program_fetch_strobe_n_o, mem_rd_n_o, mem_wr_n_o;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          lat;

  ebw_ctrl dut (.*);
  ebw_mem_model ext (.mclk_i, .bus_addr_i(mem_addr_o), .bus_wdata_i(mem_data_o),
    .fetch_n_i(program_fetch_strobe_n_o), .rd_n_i(mem_rd_n_o), .wr_n_i(mem_wr_n_o), .bus_rdata_o(mem_data_i));

  always #2.5 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_ev(string what, logic [21:0] e[$]);
    chk({what, " events"}, e.size(), ext.ev.size());
    foreach (e[i]) if (i < ext.ev.size()) chk(what, e[i], ext.ev[i]);
  endtask

  // one request, held for one clock with ready checked, then cycles counted up to the answer
  task automatic access(logic f, w, wd, p, logic [19:0] a, logic [7:0] af, op, logic [15:0] d, logic [2:0] pw, dw);
    @(negedge mclk_i);
    {req_fetch_i, req_write_i, req_word_i, req_prefixed_i} = {f, w, wd, p};
    {req_addr_i, req_addressing_field_i, req_operation_field_i, req_wdata_i} = {a, af, op, d};
    {program_wait_count_i, data_wait_count_i} = {pw, dw};
    req_valid_i = 1'b1;
    ext.ev.delete();
    chk("ready idle", 1, req_ready_o);
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    // the taking edge counts as the first cycle
    lat = 1;
    while (rsp_valid_o !== 1'b1) begin
      @(posedge mclk_i);
      #1;
      lat++;
      if (lat > 200) begin
        error_cnt++;
        $display("[FAIL] answer wait expected done seen timeout");
        close_out();
      end
    end
  endtask

  // external data access with the expected bus sequence worked out from the write, word and dummy flags
  task automatic data_op(logic w, wd, p, dum, logic [19:0] a, logic [7:0] af, op, logic [2:0] dw);
    logic [21:0] e[$];
    logic [15:0] d;
    d = {~a[7:0], a[7:0] ^ 8'h3C};
    if (w && dum) for (int i = 0; i <= int'(wd); i++) e.push_back({2'h0, a + 20'(i)});
    for (int i = 0; i <= int'(wd); i++) e.push_back({1'b0, w, a + 20'(i)});
    access(1'b0, w, wd, p, a, af, op, d, 3'h0, dw);
    chk("data latency", e.size() * (5 + dw) + 1, lat);
    chk("data internal flag", 0, rsp_internal_o);
    chk_ev("data bus", e);
    if (w) chk("low byte stored", d[7:0], ext.mem[a]);
    if (w && wd) chk("high byte stored", d[15:8], ext.mem[a + 20'h1]);
    if (!w) chk("read low byte", a[7:0] ^ 8'hA5, rsp_rdata_o[7:0]);
    if (!w && wd) chk("read high byte", a[7:0] ^ 8'hA4, rsp_rdata_o[15:8]);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_fetch();
    access(1'b1, 1'b0, 1'b0, 1'b0, 20'h0FFFF, 8'h00, 8'h00, 16'h0000, 3'h7, 3'h0);
    chk("fetch internal", 33'h0_0000_0003, {lat, rsp_internal_o});
    for (int w = 0; w < 8; w++) begin
      access(1'b1, 1'b0, 1'b0, 1'b0, 20'h10000 + 20'(w), 8'h00, 8'h00, 16'h0000, 3'(w), 3'h0);
      chk("fetch latency", w + 3, lat);
      chk_ev("fetch", '{{2'h2, 20'h10000 + 20'(w)}});
      if (w >= 2) chk("fetch data", 8'(w) ^ 8'hA5, rsp_rdata_o[7:0]);
    end
    @(negedge mclk_i);
    external_access_select_n_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    access(1'b1, 1'b0, 1'b0, 1'b0, 20'h00100, 8'h00, 8'h00, 16'h0000, 3'h1, 3'h0);
    chk("low fetch latency", 4, lat);
    chk_ev("low fetch", '{{2'h2, 20'h00100}});
    @(negedge mclk_i);
    external_access_select_n_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    $display("test fetch done");
  endtask

  task automatic t_data();
    access(1'b0, 1'b0, 1'b0, 1'b0, 20'h011FF, 8'h00, 8'h00, 16'h0000, 3'h0, 3'h5);
    chk("data internal", 33'h0_0000_0003, {lat, rsp_internal_o});
    chk("internal rdata", 0, rsp_rdata_o);
    for (int dw = 0; dw < 8; dw++) data_op(1'b0, 1'b0, 1'b0, 1'b0, 20'h01200 + 20'(dw), 8'h00, 8'h00, 3'(dw));
    data_op(1'b0, 1'b1, 1'b0, 1'b0, 20'hFFFFE, 8'h00, 8'h00, 3'h2);
    $display("test data read done");
  endtask

  task automatic t_dummy();
    logic [7:0] ops[$] = '{8'hB8, 8'hB9, 8'hCA, 8'hBB, 8'hBA, 8'hAA, 8'hAB, 8'hC7, 8'hD7};
    logic [7:0] afs[$] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB5, 8'hB7, 8'hB8, 8'hB9, 8'h9B, 8'hBA, 8'hBB};
    logic [7:0] wop[$] = '{8'hAA, 8'hAB, 8'hC7, 8'hD7};
    logic [7:0] waf[$] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA5, 8'hA7, 8'hA8, 8'hA9, 8'h8B, 8'hAA, 8'hAB};
    for (int b = 0; b < 8; b++) ops.push_back(8'h08 + 8'(b));
    for (int b = 0; b < 8; b++) ops.push_back(8'h00 + 8'(b));
    for (int b = 0; b < 8; b++) ops.push_back(8'h18 + 8'(b));
    for (int n = 0; n < 8; n++) afs.push_back(8'h68 + 8'(n));
    for (int n = 0; n < 4; n++) waf.push_back(8'h64 + 8'(n));
    foreach (ops[i]) data_op(1'b1, 1'b0, 1'b1, 1'b1, 20'h02000 + 20'(i), 8'hB7, ops[i], 3'h0);
    foreach (afs[i]) data_op(1'b1, 1'b0, 1'b1, 1'b1, 20'h03000 + 20'(i), afs[i], 8'hC7, 3'h1);
    foreach (wop[i]) foreach (waf[j])
      data_op(1'b1, 1'b1, 1'b1, 1'b1, 20'h04000 + 20'(i * 64 + j * 2), waf[j], wop[i], 3'h1);
    access(1'b0, 1'b1, 1'b1, 1'b1, 20'h00800, 8'hA7, 8'hC7, 16'h1234, 3'h0, 3'h0);
    chk("internal prefixed write", 33'h0_0000_0003, {lat, rsp_internal_o});
    chk("internal prefixed bus", 0, ext.ev.size());
    $display("test dummy read done");
  endtask

  task automatic t_plain();
    data_op(1'b1, 1'b0, 1'b0, 1'b0, 20'h05000, 8'hB7, 8'hC7, 3'h2);
    data_op(1'b1, 1'b1, 1'b0, 1'b0, 20'h05010, 8'hA7, 8'hAA, 3'h0);
    $display("test plain write done");
  endtask

  initial begin
    {nrst_i, req_valid_i, req_fetch_i, req_write_i, req_word_i, req_prefixed_i} = 6'h00;
    {req_addr_i, req_addressing_field_i, req_operation_field_i, req_wdata_i} = 52'h0;
    {program_wait_count_i, data_wait_count_i} = 6'h00;
    external_access_select_n_i = 1'b1;
    repeat (12) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_fetch();
    t_data();
    t_dummy();
    t_plain();
    chk("address hold errors", 0, ext.hold_err);
    close_out();
  end
endmodule
